// ==== byte_cpu_regs.svh ====
`ifndef BYTE_CPU_REGS_SVH
`define BYTE_CPU_REGS_SVH
`define ST_WAIT 3'h0
`define ST_T3 3'h1
`define ST_T1 3'h2
`define ST_STOP 3'h3
`define ST_T2 3'h4
`define ST_T4 3'h7
`define CYC_CODE_FETCH 2'h0
`define CYC_CODE_IO 2'h1
`define CYC_CODE_READ 2'h2
`define CYC_CODE_WRITE 2'h3
`define REG_A 3'h0
`define REG_H 3'h5
`define REG_L 3'h6
`define SEL_MEM 3'h7
`define OP_ADD 3'h0
`define OP_ADC 3'h1
`define OP_SUB 3'h2
`define OP_SBB 3'h3
`define OP_AND 3'h4
`define OP_XOR 3'h5
`define OP_OR 3'h6
`define OP_CMP 3'h7
`define CC_CARRY 2'h0
`define CC_ZERO 2'h1
`define CC_SIGN 2'h2
`define CC_PARITY 2'h3
`define OPC_HALT_ALT 8'hFF
`define OPC_STORE_IMM 8'h3E
`define RESET_PC 14'h0000
`define RESET_SLOT 3'h0
`define STACK_DEPTH 7
`endif

// ==== byte_cpu_pkg.sv ====
package byte_cpu_pkg;
  typedef logic [13:0] addr_t;
  typedef logic [2:0] slot_t;
  typedef enum logic [2:0] {PH_T1, PH_T2, PH_T3, PH_T4, PH_STOP} phase_t;
  typedef enum logic [1:0] {CYC_FETCH, CYC_READ, CYC_WRITE, CYC_IO} cycle_t;
  typedef struct packed {
    phase_t phase;
    cycle_t cyc;
    logic [1:0] step;
    logic use_hl;
    addr_t pc;
    logic [7:0] ir;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [6:0][7:0] regs;
    logic cf;
    logic zf;
    logic sf;
    logic pf;
    slot_t sp;
    logic [7:0] data_out;
    logic data_oe;
    logic [2:0] state_code;
  } core_state_t;
endpackage : byte_cpu_pkg

// ==== stack_if.sv ====
`timescale 1ns/100ps
interface stack_if;
  import byte_cpu_pkg::*;
  logic wr_en;
  slot_t wr_addr;
  addr_t wr_data;
  slot_t rd_addr;
  addr_t rd_data;
  modport core (output wr_en, output wr_addr, output wr_data, output rd_addr,
    input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
    output rd_data);
endinterface : stack_if

// ==== return_stack_mem.sv ====
`timescale 1ns/100ps
`include "byte_cpu_regs.svh"
module return_stack_mem
  import byte_cpu_pkg::*;
#(
  parameter int DEPTH = `STACK_DEPTH
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  stack_if.mem port
);
  addr_t mem_reg [DEPTH];
  addr_t rd_reg;

  // Saved return addresses
  always_ff @(posedge clock_in) begin
    if (port.wr_en) begin
      mem_reg[port.wr_addr] <= port.wr_data;
    end
  end

  // Registered read of the top entry
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_reg <= `RESET_PC;
    end else if (port.wr_en && port.wr_addr == port.rd_addr) begin
      rd_reg <= port.wr_data;
    end else begin
      rd_reg <= mem_reg[port.rd_addr];
    end
  end

  assign port.rd_data = rd_reg;
endmodule : return_stack_mem

// ==== byte_cpu_core.sv ====
`timescale 1ns/100ps
`include "byte_cpu_regs.svh"
module byte_cpu_core
  import byte_cpu_pkg::*;
#(
  parameter int STACK_DEPTH = `STACK_DEPTH
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [7:0] data_in,
  input wire logic ready_in,
  input wire logic resume_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic [2:0] state_code_out
);
  core_state_t r_reg;
  core_state_t r_next;
  stack_if stk ();

  return_stack_mem #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .port(stk.mem)
  );

  // Register read; memory code gives zero
  function automatic logic [7:0] reg_get(input core_state_t s, input logic [2:0] code);
    reg_get = (code == `SEL_MEM) ? 8'h00 : s.regs[code];
  endfunction : reg_get

  // Carry out and result of the ALU
  function automatic logic [8:0] alu(input logic [2:0] op, input logic [7:0] a,
      input logic [7:0] b, input logic c);
    logic [8:0] sum;
    sum = 9'h000;
    case (op)
      `OP_ADD: sum = {1'b0, a} + {1'b0, b};
      `OP_ADC: sum = {1'b0, a} + {1'b0, b} + {8'h00, c};
      `OP_SUB: sum = {1'b0, a} - {1'b0, b};
      `OP_SBB: sum = {1'b0, a} - {1'b0, b} - {8'h00, c};
      `OP_AND: sum = {1'b0, a & b};
      `OP_XOR: sum = {1'b0, a ^ b};
      `OP_OR: sum = {1'b0, a | b};
      default: sum = {1'b0, a} - {1'b0, b};
    endcase
    alu = sum;
  endfunction : alu

  function automatic slot_t slot_step(input slot_t s, input logic up);
    if (up) begin
      slot_step = (s == slot_t'(STACK_DEPTH - 1)) ? `RESET_SLOT : s + 3'h1;
    end else begin
      slot_step = (s == `RESET_SLOT) ? slot_t'(STACK_DEPTH - 1) : s - 3'h1;
    end
  endfunction : slot_step

  always_comb begin
    logic [7:0] ir;
    logic [2:0] dst;
    logic [2:0] src;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [8:0] alu_out;
    logic cond_hit;
    logic done;
    logic push;
    logic pop;
    addr_t hl;
    addr_t addr;
    addr_t target;
    r_next = r_reg;
    ir = r_reg.ir;
    dst = ir[5:3];
    src = ir[2:0];
    opnd = 8'h00;
    res = 8'h00;
    alu_out = 9'h000;
    done = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    target = `RESET_PC;
    addr = `RESET_PC;
    cond_hit = 1'b0;
    hl = {r_reg.regs[`REG_H][5:0], r_reg.regs[`REG_L]};
    case (ir[4:3])
      `CC_CARRY: cond_hit = r_reg.cf;
      `CC_ZERO: cond_hit = r_reg.zf;
      `CC_SIGN: cond_hit = r_reg.sf;
      default: cond_hit = r_reg.pf;
    endcase
    cond_hit = (cond_hit == ir[5]);

    case (r_reg.phase)
      PH_T1: begin
        r_next.phase = PH_T2;
      end
      PH_T2: begin
        r_next.phase = PH_T3;
      end
      PH_T3: begin
        if (ready_in) begin
          r_next.phase = PH_T4;
          case (r_reg.cyc)
            CYC_FETCH: begin
              r_next.ir = data_in;
              r_next.pc = r_reg.pc + 14'h0001;
            end
            CYC_READ: begin
              if (r_reg.step == 2'h2) begin
                r_next.b3 = data_in;
              end else begin
                r_next.b2 = data_in;
              end
              if (!r_reg.use_hl) begin
                r_next.pc = r_reg.pc + 14'h0001;
              end
            end
            CYC_IO: begin
              if (ir[5:4] == 2'h0) begin
                r_next.regs[`REG_A] = data_in;
              end
            end
            default: begin
            end
          endcase
        end
      end
      PH_T4: begin
        if (r_reg.cyc == CYC_WRITE || r_reg.cyc == CYC_IO) begin
          done = 1'b1;
        end else if (r_reg.step == 2'h0) begin
          casez (ir)
            8'b0000000?, `OPC_HALT_ALT: begin
              r_next.phase = PH_STOP;
            end
            8'b11111???: begin
              r_next.cyc = CYC_WRITE;
              r_next.use_hl = 1'b1;
            end
            8'b11???111, 8'b10???111: begin
              r_next.cyc = CYC_READ;
              r_next.use_hl = 1'b1;
            end
            8'b11??????: begin
              r_next.regs[dst] = reg_get(r_reg, src);
              done = 1'b1;
            end
            8'b10??????: begin
              opnd = reg_get(r_reg, src);
              done = 1'b1;
            end
            8'b00???110, 8'b00???100: begin
              r_next.cyc = CYC_READ;
              r_next.use_hl = 1'b0;
            end
            8'b00???00?: begin
              if (dst != `SEL_MEM) begin
                res = ir[0] ? reg_get(r_reg, dst) - 8'h01 : reg_get(r_reg, dst) + 8'h01;
                r_next.regs[dst] = res;
                r_next.zf = (res == 8'h00);
                r_next.sf = res[7];
                r_next.pf = ~^res;
              end
              done = 1'b1;
            end
            8'b00???010: begin
              res = reg_get(r_reg, `REG_A);
              case (dst)
                3'h0: begin
                  r_next.regs[`REG_A] = {res[6:0], res[7]};
                  r_next.cf = res[7];
                end
                3'h1: begin
                  r_next.regs[`REG_A] = {res[0], res[7:1]};
                  r_next.cf = res[0];
                end
                3'h2: begin
                  r_next.regs[`REG_A] = {res[6:0], r_reg.cf};
                  r_next.cf = res[7];
                end
                3'h3: begin
                  r_next.regs[`REG_A] = {r_reg.cf, res[7:1]};
                  r_next.cf = res[0];
                end
                default: begin
                end
              endcase
              done = 1'b1;
            end
            8'b00???111: begin
              pop = 1'b1;
              done = 1'b1;
            end
            8'b00???011: begin
              pop = cond_hit;
              done = 1'b1;
            end
            8'b00???101: begin
              push = 1'b1;
              target = {8'h00, dst, 3'h0};
              done = 1'b1;
            end
            8'b01?????1: begin
              r_next.cyc = CYC_IO;
            end
            default: begin
              r_next.cyc = CYC_READ;
              r_next.use_hl = 1'b0;
            end
          endcase
          r_next.step = 2'h1;
        end else if (r_reg.step == 2'h1) begin
          casez (ir)
            8'b11??????: begin
              r_next.regs[dst] = r_reg.b2;
              done = 1'b1;
            end
            8'b10??????, 8'b00???100: begin
              opnd = r_reg.b2;
              done = 1'b1;
            end
            `OPC_STORE_IMM: begin
              r_next.cyc = CYC_WRITE;
              r_next.use_hl = 1'b1;
            end
            8'b00??????: begin
              r_next.regs[dst] = r_reg.b2;
              done = 1'b1;
            end
            default: begin
              r_next.cyc = CYC_READ;
              r_next.use_hl = 1'b0;
            end
          endcase
          r_next.step = 2'h2;
        end else begin
          target = {r_reg.b3[5:0], r_reg.b2};
          if (ir[2] || cond_hit) begin
            r_next.pc = target;
            push = ir[1];
          end
          done = 1'b1;
        end
        if ((ir[7:6] == 2'h2 || ir ==? 8'b00???100) && done) begin
          alu_out = alu(ir[5:3], reg_get(r_reg, `REG_A), opnd, r_reg.cf);
          res = alu_out[7:0];
          if (ir[5:3] != `OP_CMP) begin
            r_next.regs[`REG_A] = res;
          end
          r_next.cf = alu_out[8];
          r_next.zf = (res == 8'h00);
          r_next.sf = res[7];
          r_next.pf = ~^res;
        end
        if (push) begin
          r_next.sp = slot_step(r_reg.sp, 1'b1);
          r_next.pc = target;
        end
        if (pop) begin
          r_next.pc = stk.rd_data;
          r_next.sp = slot_step(r_reg.sp, 1'b0);
        end
        if (done) begin
          r_next.phase = PH_T1;
          r_next.cyc = CYC_FETCH;
          r_next.step = 2'h0;
        end
        if (r_next.phase != PH_STOP && !done) begin
          r_next.phase = PH_T1;
        end
      end
      default: begin
        if (resume_in) begin
          r_next.phase = PH_T1;
          r_next.cyc = CYC_FETCH;
          r_next.step = 2'h0;
        end
      end
    endcase

    // Bus drive for the state being entered
    hl = {r_next.regs[`REG_H][5:0], r_next.regs[`REG_L]};
    addr = r_next.use_hl ? hl : r_next.pc;
    if (r_next.cyc == CYC_FETCH) begin
      addr = r_next.pc;
    end
    r_next.data_oe = 1'b0;
    r_next.data_out = 8'h00;
    case (r_next.phase)
      PH_T1: begin
        r_next.state_code = `ST_T1;
        r_next.data_oe = 1'b1;
        r_next.data_out = (r_next.cyc == CYC_IO) ? r_next.regs[`REG_A] : addr[7:0];
      end
      PH_T2: begin
        r_next.state_code = `ST_T2;
        r_next.data_oe = 1'b1;
        case (r_next.cyc)
          CYC_FETCH: r_next.data_out = {`CYC_CODE_FETCH, addr[13:8]};
          CYC_READ: r_next.data_out = {`CYC_CODE_READ, addr[13:8]};
          CYC_WRITE: r_next.data_out = {`CYC_CODE_WRITE, addr[13:8]};
          default: r_next.data_out = r_next.ir;
        endcase
      end
      PH_T3: begin
        r_next.state_code = (r_reg.phase == PH_T3) ? `ST_WAIT : `ST_T3;
        if (r_next.cyc == CYC_WRITE) begin
          r_next.data_oe = 1'b1;
          r_next.data_out = (r_next.ir == `OPC_STORE_IMM) ? r_next.b2 :
            reg_get(r_next, r_next.ir[2:0]);
        end
      end
      PH_T4: begin
        r_next.state_code = `ST_T4;
        if (r_next.cyc == CYC_IO) begin
          r_next.data_oe = 1'b1;
          r_next.data_out = {4'h0, r_next.cf, r_next.pf, r_next.zf, r_next.sf};
        end
      end
      default: begin
        r_next.state_code = `ST_STOP;
      end
    endcase

    stk.wr_en = push;
    stk.wr_addr = r_reg.sp;
    stk.wr_data = r_reg.pc;
    stk.rd_addr = slot_step(r_reg.sp, 1'b0);
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // Start up stopped, as after a halt
      r_reg <= '0;
      r_reg.phase <= PH_STOP;
      r_reg.state_code <= `ST_STOP;
    end else begin
      r_reg <= r_next;
    end
  end

  assign data_out = r_reg.data_out;
  assign data_oe_out = r_reg.data_oe;
  assign state_code_out = r_reg.state_code;
endmodule : byte_cpu_core

// ==== cpu_bus_model.sv ====
`timescale 1ns/100ps
`include "byte_cpu_regs.svh"
module cpu_bus_model #(
  parameter logic [7:0] PORT_DATA = 8'hC3
) (
  input wire logic clock_in,
  input wire logic [7:0] bus_in,
  input wire logic [2:0] state_in,
  input wire logic slow_in,
  output logic [7:0] rd_data_out,
  output logic ready_out
);
  logic [7:0] mem [0:16383];
  logic [7:0] outs [$];
  logic [7:0] flgs [$];
  logic [13:0] adr = 14'h0000;
  logic [7:0] acc = 8'h00;
  logic [7:0] ins = 8'h00;
  logic [1:0] typ = 2'h0;
  logic [1:0] wt = 2'h0;
  initial begin
    rd_data_out = 8'h00;
    ready_out = 1'b0;
  end
  // Bus off the answer slot toggles so no stale byte reads as valid
  always @(negedge clock_in) begin
    ready_out <= 1'b0;
    rd_data_out <= ~rd_data_out;
    wt <= 2'h0;
    case (state_in)
      `ST_T1: begin
        adr[7:0] <= bus_in;
        acc <= bus_in;
      end
      `ST_T2: begin
        typ <= bus_in[7:6];
        adr[13:8] <= bus_in[5:0];
        ins <= bus_in;
        if (bus_in[7:6] == `CYC_CODE_IO && bus_in[5:4] != 2'h0) outs.push_back(acc);
      end
      `ST_T3, `ST_WAIT: if (slow_in && wt < 2'h2) begin
        wt <= wt + 2'h1;
      end else begin
        ready_out <= 1'b1;
        rd_data_out <= (typ == `CYC_CODE_IO) ? PORT_DATA : mem[adr];
        if (typ == `CYC_CODE_WRITE) mem[adr] <= bus_in;
      end
      `ST_T4: if (typ == `CYC_CODE_IO && ins[5:4] == 2'h0) flgs.push_back(bus_in);
      default: ;
    endcase
  end
endmodule : cpu_bus_model

// ==== byte_cpu_core_assertions.sv ====
`timescale 1ns/100ps
`include "byte_cpu_regs.svh"
module byte_cpu_core_assertions #(
  parameter int STACK_DEPTH = 7
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [7:0] data_in,
  input wire logic ready_in,
  input wire logic resume_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_out,
  input wire logic [2:0] state_code_out
);
  wire [2:0] st = state_code_out;
  logic io_in_reg;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Marks a port read cycle from its T2 byte
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      io_in_reg <= 1'b0;
    end else if (st == `ST_T2) begin
      io_in_reg <= data_out[7:4] == 4'h4;
    end
  end
  t1_then_t2_a: assert property (st == `ST_T1 |=> st == `ST_T2)
    else $error("T1 not followed by T2");
  t2_then_t3_a: assert property (st == `ST_T2 |=> st == `ST_T3)
    else $error("T2 not followed by T3");
  wait_on_ready_a: assert property (st == `ST_T3 && !ready_in |=> st == `ST_WAIT)
    else $error("T3 left without ready");
  ready_ends_t3_a: assert property (st == `ST_T3 && ready_in |=> st == `ST_T4 || st == `ST_STOP)
    else $error("T3 not ended by ready");
  wait_release_a: assert property (st == `ST_T3 ##1 st == `ST_WAIT ##1 (st == `ST_WAIT && ready_in)
    |=> st == `ST_T4 || st == `ST_STOP)
    else $error("wait not ended by ready");
  t4_exit_a: assert property (st == `ST_T4 |=> st == `ST_T1 || st == `ST_STOP)
    else $error("T4 not followed by T1");
  addr_driven_a: assert property (st == `ST_T1 || st == `ST_T2 |-> data_oe_out)
    else $error("bus not driven in T1 or T2");
  stop_floats_a: assert property (st == `ST_STOP |-> !data_oe_out)
    else $error("bus driven while stopped");
  stop_holds_a: assert property (st == `ST_STOP && !resume_in |=> st == `ST_STOP)
    else $error("stop left without resume");
  resume_fetch_a: assert property (st == `ST_STOP && resume_in |=> st == `ST_T1)
    else $error("resume did not start a fetch");
  write_drives_a: assert property (st == `ST_T2 && data_out[7:6] == `CYC_CODE_WRITE
    |=> st == `ST_T3 && data_oe_out)
    else $error("write data not driven in T3");
  read_floats_a: assert property (st == `ST_T2 && data_out[7:6] != `CYC_CODE_WRITE
    |=> !data_oe_out)
    else $error("bus driven in a read T3");
  flags_out_a: assert property (st == `ST_T4 && io_in_reg |-> data_oe_out && data_out[7:4] == 4'h0)
    else $error("flag byte wrong in port read T4");
  cover property (st == `ST_STOP);
  cover property (st == `ST_WAIT ##1 st == `ST_T4);
  cover property (st == `ST_T3 && data_oe_out);
  cover property (st == `ST_T4 && io_in_reg);
endmodule : byte_cpu_core_assertions
bind byte_cpu_core byte_cpu_core_assertions #(.STACK_DEPTH(STACK_DEPTH)) i_chk (
  .clock_in(clock_in),
  .rst_b_in(rst_b_in),
  .data_in(data_in),
  .ready_in(ready_in),
  .resume_in(resume_in),
  .data_out(data_out),
  .data_oe_out(data_oe_out),
  .state_code_out(state_code_out)
);

// ==== byte_cpu_instruction_execute_test.sv ====
`timescale 1ns/100ps
`include "byte_cpu_regs.svh"
module byte_cpu_instruction_execute_test;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic resume_in = 1'b0;
  logic slow = 1'b0;
  logic ready_in;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic data_oe_out;
  logic [2:0] state_code_out;
  logic [7:0] eo [$];
  logic [7:0] ef [$];
  logic [8:0] r;
  logic [7:0] a;
  logic [2:0] op;
  logic c;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int base = 0;
  always #4 clock_in = ~clock_in;
  byte_cpu_core #(.STACK_DEPTH(7)) i_dut (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .data_in(data_in),
    .ready_in(ready_in),
    .resume_in(resume_in),
    .data_out(data_out),
    .data_oe_out(data_oe_out),
    .state_code_out(state_code_out)
  );
  cpu_bus_model i_mem (
    .clock_in(clock_in),
    .bus_in(data_out),
    .state_in(state_code_out),
    .slow_in(slow),
    .rd_data_out(data_in),
    .ready_out(ready_in)
  );
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task ld(input logic [255:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      i_mem.mem[base] = v[8*(n-1-i) +: 8];
      base++;
    end
  endtask : ld
  task run(input string nm);
    resume_in = 1'b1;
    @(negedge clock_in);
    resume_in = 1'b0;
    for (int i = 0; i < 9000 && state_code_out !== `ST_STOP; i++) @(negedge clock_in);
    chk("stop code", 8'(`ST_STOP), 8'(state_code_out));
    chk("out count", 8'(eo.size()), 8'(i_mem.outs.size()));
    repeat (eo.size()) chk("out", eo.pop_front(), i_mem.outs.pop_front());
    chk("flag count", 8'(ef.size()), 8'(i_mem.flgs.size()));
    repeat (ef.size()) chk("flags", ef.pop_front(), i_mem.flgs.pop_front());
    i_mem.outs.delete();
    i_mem.flgs.delete();
    $display("test %s done", nm);
  endtask : run
  function automatic logic [8:0] alu(input logic [2:0] o, input logic [7:0] x, input logic ci);
    logic [8:0] p;
    logic [8:0] q;
    p = {1'b0, x};
    q = 9'h070;
    case (o)
      3'h0: return p + q;
      3'h1: return p + q + ci;
      3'h2, 3'h7: return p - q;
      3'h3: return p - q - ci;
      3'h4: return p & q;
      3'h5: return p ^ q;
      default: return p | q;
    endcase
  endfunction : alu
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("[FAIL] run time expected 20000 seen %0d", cycles);
      close_out;
    end
  end
  initial begin
    ld(24'h440004, 3);
    base = 16'h0400;
    ld(176'h0E7F0841C1512E7F3620F836213E5AC75109C9C15100, 22);
    eo = '{8'h80, 8'h5A, 8'h7F};
    ef = '{8'h01};
    repeat (12) @(negedge clock_in);
    rst_b_in = 1'b1;
    run("moves");
    chk("mem 3F20", 8'h80, i_mem.mem[16'h3F20]);
    chk("mem 3F21", 8'h5A, i_mem.mem[16'h3F21]);
    slow = 1'b1;
    c = 1'b0;
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 8; k++) begin
        a = p[0] ? 8'h30 : 8'hA0;
        op = k[2:0];
        if (p == 0) ld({8'h06, a, 2'h0, op, 3'h4, 8'h70, 16'h5141}, 6);
        if (p == 1) ld({8'h06, a, 8'h0E, 8'h70, 2'h2, op, 3'h1, 16'h5141}, 7);
        if (p == 2) ld({8'h06, a, 40'h2E7F36223E, 8'h70, 2'h2, op, 3'h7, 16'h5141}, 11);
        r = alu(op, a, c);
        c = r[8];
        eo.push_back(op == 3'h7 ? a : r[7:0]);
        ef.push_back({4'h0, c, ~^r[7:0], r[7:0] == 8'h00, r[7]});
      end
    end
    ld(8'h00, 1);
    run("alu");
    slow = 1'b0;
    ld(120'h068124FF12511A5102510A51415100, 15);
    eo = '{8'h02, 8'h81, 8'h03, 8'h81, 8'hC3};
    ef = '{8'h0D};
    run("rotate");
    ld(24'h440001, 3);
    base = 16'h0100;
    ld(128'h060004006810C106EE51FFFFFFFFFFFF, 16);
    ld(184'h4018C106EE51FFFF5800020611514600C2516200022DFF, 23);
    base = 16'h0200;
    ld(80'h062204002B1306EE51FF, 10);
    base = 16'h0028;
    ld(32'h06335107, 4);
    eo = '{8'h11, 8'h22, 8'h33};
    run("branch");
    base = 16'h0127;
    ld(56'h0E003D06EE5100, 7);
    base = 16'h0038;
    ld(120'h08C13C0848410051073D09C1510B00, 15);
    eo = '{8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00};
    run("stack");
    close_out;
  end
endmodule : byte_cpu_instruction_execute_test
